// ==== src/lpcd_decoder.sv ====
// Command decoder top: samples select, clock gate and the DDR bus and
// reports decoded commands, the low-power state and protocol violations.
// Assumes all inputs are synchronous to ref_clk; the core consumes the
// cmd_valid pulse and keeps track of running bursts on its own.
`timescale 1ns/10ps
module lpcd_decoder #(
    parameter int CA_W = lpcd_pkg::CA_WIDTH,
    parameter int EXIT_CYCLES = lpcd_pkg::PD_EXIT_CYCLES
) (
    input  wire logic               ref_clk,
    input  wire logic               rst_n,
    input  wire logic               select_low,
    input  wire logic               clock_gate_in,
    input  wire logic [CA_W-1:0]    cmd_addr_bus,
    output logic                    cmd_valid_ff,
    output lpcd_pkg::lpcd_cmd_type  cmd_ff,
    output lpcd_pkg::lpcd_pwr_type  pwr_state_ff,
    output logic                    exit_window_ff,
    output logic                    illegal_seen_ff,
    output logic                    reinit_needed_ff
);

    generate
        if (CA_W != 10)
        begin : g_chk
            $error("lpcd_decoder: the field layout needs a 10-bit bus");
        end
        if (EXIT_CYCLES < 1)
        begin : g_chk_exit
            $error("lpcd_decoder: EXIT_CYCLES must be at least one");
        end
    endgenerate

    // Rising-edge samples of the single-rate pins
    logic            sel_s_ff;
    logic            cke_s_ff;
    logic            cke_prev_ff;
    logic [CA_W-1:0] rise_bus;
    logic [CA_W-1:0] fall_bus;

    lpcd_ddr_capture #(
        .WIDTH   (CA_W)
    ) u_capture (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .bus_in  (cmd_addr_bus),
        .rise_ff (rise_bus),
        .fall_ff (fall_bus)
    );

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // Gate samples start at the gate's idle high level, so release
            // is not taken as a gate held low while active
            sel_s_ff    <= 1'b1;
            cke_s_ff    <= 1'b1;
            cke_prev_ff <= 1'b1;
        end
        else
        begin
            sel_s_ff    <= select_low;
            cke_s_ff    <= clock_gate_in;
            cke_prev_ff <= cke_s_ff;
        end
    end

    // Edge classification of the clock gate, previous edge against current
    logic cke_hh;
    logic cke_hl;
    logic cke_ll;
    logic cke_lh;

    assign cke_hh = cke_prev_ff & cke_s_ff;
    assign cke_hl = cke_prev_ff & ~cke_s_ff;
    assign cke_ll = ~cke_prev_ff & ~cke_s_ff;
    assign cke_lh = ~cke_prev_ff & cke_s_ff;

    // Only select, clock gate and rising bits 0-3 identify a command
    logic       sel_act;
    logic [3:0] opc;

    assign sel_act = ~sel_s_ff;
    assign opc     = rise_bus[3:0];

    logic is_nop_enc;
    logic is_mrw;
    logic is_mrr;
    logic is_refpb;
    logic is_refab;
    logic is_act;
    logic is_rd;
    logic is_wr;
    logic is_pre;

    assign is_nop_enc = sel_s_ff | (opc[2:0] == lpcd_pkg::OP_NOP);
    assign is_mrw   = sel_act & (opc == lpcd_pkg::OP_MRW);
    assign is_mrr   = sel_act & (opc == lpcd_pkg::OP_MRR);
    assign is_refpb = sel_act & (opc == lpcd_pkg::OP_REFPB);
    assign is_refab = sel_act & (opc == lpcd_pkg::OP_REFAB);
    assign is_act   = sel_act & (opc[1:0] == lpcd_pkg::OP_ACT);
    assign is_rd    = sel_act & (opc[2:0] == lpcd_pkg::OP_RD);
    assign is_wr    = sel_act & (opc[2:0] == lpcd_pkg::OP_WR);
    assign is_pre   = sel_act & (opc == lpcd_pkg::OP_PRE);

    logic is_self_refresh_state_enc;
    logic is_dpd_enc;

    assign is_self_refresh_state_enc = sel_act & (opc[2:0] == lpcd_pkg::OP_SELF_REFRESH_STATE);
    assign is_dpd_enc  = sel_act & (opc[2:0] == lpcd_pkg::OP_DPD);

    // Command kind, valid only while the gate stays high on both edges
    lpcd_pkg::lpcd_kind_type kind;

    assign kind = !cke_hh  ? lpcd_pkg::CMD_NONE :
                  is_mrw   ? lpcd_pkg::CMD_MRW :
                  is_mrr   ? lpcd_pkg::CMD_MRR :
                  is_refpb ? lpcd_pkg::CMD_REFPB :
                  is_refab ? lpcd_pkg::CMD_REFAB :
                  is_act   ? lpcd_pkg::CMD_ACT :
                  is_rd    ? lpcd_pkg::CMD_RD :
                  is_wr    ? lpcd_pkg::CMD_WR :
                  is_pre   ? lpcd_pkg::CMD_PRE :
                  lpcd_pkg::CMD_NONE;

    logic real_cmd;

    assign real_cmd = (kind != lpcd_pkg::CMD_NONE);

    // Field extraction from the two halves
    logic [2:0]  bank;
    logic [14:0] row;
    logic [11:0] col;
    logic [7:0]  mr_idx;
    logic [7:0]  mr_pay;
    logic        auto_close;
    logic        all_banks;

    assign bank   = rise_bus[lpcd_pkg::BANK_LSB +: 3];
    assign row    = {fall_bus[9:8], rise_bus[6:2], fall_bus[7:0]};
    assign col    = {fall_bus[9:1], rise_bus[6:5], 1'b0};
    assign mr_idx = {fall_bus[1:0], rise_bus[lpcd_pkg::MRI_LSB +: 6]};
    assign mr_pay = fall_bus[9:2];
    assign auto_close = fall_bus[lpcd_pkg::AUTO_CLOSE_BIT]
                        & (is_rd | is_wr);
    assign all_banks  = rise_bus[lpcd_pkg::ALL_BANKS_BIT] & is_pre;

    // Fields that a command does not use are cleared, so the core never
    // mistakes stale bus contents for an address
    lpcd_pkg::lpcd_cmd_type nxt_cmd;

    assign nxt_cmd.kind = kind;
    assign nxt_cmd.array_group_sel = ((is_act | is_rd | is_wr | is_pre) & ~all_banks)
                                     ? bank : 3'h0;
    assign nxt_cmd.row_index_bits  = is_act ? row : 15'h0000;
    assign nxt_cmd.col_index_bits  = (is_rd | is_wr) ? col : 12'h000;
    assign nxt_cmd.mode_reg_index  = (is_mrw | is_mrr) ? mr_idx : 8'h00;
    assign nxt_cmd.mode_reg_payload = is_mrw ? mr_pay : 8'h00;
    assign nxt_cmd.auto_close_flag = auto_close;
    assign nxt_cmd.all_banks_flag  = all_banks;

    // Violation summary, formed further down; a refused cycle never
    // reaches the command register
    logic illegal_now;

    // A no-operation raises no pulse and leaves the last command standing,
    // so a burst that the core is running is neither cut nor changed
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmd_valid_ff <= 1'b0;
            cmd_ff       <= lpcd_pkg::CMD_RESET;
        end
        else
        begin
            cmd_valid_ff <= real_cmd & ~illegal_now;
            if (real_cmd & ~illegal_now)
                cmd_ff <= nxt_cmd;
        end
    end

    // Low-power state machine
    lpcd_pkg::lpcd_pwr_type nxt_pwr;
    logic                   enter_bad;
    logic                   exit_bad;

    always_comb
    begin
        nxt_pwr   = pwr_state_ff;
        enter_bad = 1'b0;
        exit_bad  = 1'b0;
        case (pwr_state_ff)
            lpcd_pkg::PWR_ACTIVE:
            begin
                if (cke_hl)
                begin
                    if (sel_s_ff)
                        nxt_pwr = lpcd_pkg::PWR_PD;
                    else if (is_self_refresh_state_enc)
                        nxt_pwr = lpcd_pkg::PWR_SELF_REFRESH_STATE;
                    else if (is_dpd_enc)
                        nxt_pwr = lpcd_pkg::PWR_DPD;
                    else
                        enter_bad = 1'b1;
                end
            end
            lpcd_pkg::PWR_PD,
            lpcd_pkg::PWR_SELF_REFRESH_STATE,
            lpcd_pkg::PWR_DPD:
            begin
                // Low on both edges keeps the state whatever the other pins do,
                // since they may float once the gate has settled
                if (cke_lh)
                begin
                    if (sel_s_ff)
                        nxt_pwr = lpcd_pkg::PWR_ACTIVE;
                    else
                        exit_bad = 1'b1;
                end
            end
            default:
            begin
                nxt_pwr = lpcd_pkg::PWR_ACTIVE;
            end
        endcase
    end

    logic pwr_exit;
    logic dpd_exit;

    assign pwr_exit = (pwr_state_ff != lpcd_pkg::PWR_ACTIVE)
                      & (nxt_pwr == lpcd_pkg::PWR_ACTIVE);
    assign dpd_exit = (pwr_state_ff == lpcd_pkg::PWR_DPD) & pwr_exit;

    // Exit from self refresh and deep sleep is taken on the first rising
    // edge that sees the gate high; the clock is required stable before it
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            pwr_state_ff <= lpcd_pkg::PWR_ACTIVE;
        else
            pwr_state_ff <= nxt_pwr;
    end

    // Exit window after leaving a low-power state
    logic exit_busy;

    lpcd_gap_timer #(
        .CYCLES  (EXIT_CYCLES)
    ) u_exit_timer (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .start   (pwr_exit),
        .busy_ff (exit_busy)
    );

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            exit_window_ff <= 1'b0;
        else
            exit_window_ff <= exit_busy;
    end

    // Violations the device can see at its pins
    // Pins held in a low-power state are not judged, since they may float
    logic nop_unstable;
    logic early_cmd;
    logic hh_unknown;
    logic low_cmd;

    // A select-low no-operation while the gate changes level is an illegal
    // encoding that matches no entry or exit row
    assign nop_unstable = ~sel_s_ff & is_nop_enc & (cke_hl | cke_lh)
                          & ~is_self_refresh_state_enc & ~is_dpd_enc;
    assign early_cmd    = exit_busy & cke_hh & sel_act & ~is_nop_enc;
    assign hh_unknown   = cke_hh & sel_act & ~is_nop_enc & ~real_cmd;
    assign low_cmd      = (pwr_state_ff == lpcd_pkg::PWR_ACTIVE) & cke_ll;
    assign illegal_now  = nop_unstable | early_cmd | hh_unknown | low_cmd
                          | enter_bad | exit_bad;

    // Sticky until reset: recovery needs a full power cycle and
    // reinitialisation, which the decoder cannot do by itself
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            illegal_seen_ff <= 1'b0;
        else if (illegal_now)
            illegal_seen_ff <= 1'b1;
    end

    // Deep sleep loses the array contents, so the core must reinitialise
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            reinit_needed_ff <= 1'b0;
        else if (dpd_exit | illegal_now)
            reinit_needed_ff <= 1'b1;
    end

endmodule : lpcd_decoder

// ==== src/lpcd_pkg.sv ====
// Constants, field layouts and carrier types of the command/address decoder.
// Assumes a single 100 MHz clock and inputs synchronous to it.
// Overview of operation
// - No-operation is select high, or select low with bits 0-2 high.
// - A no-operation never aborts or changes an operation still in progress.
// - Commands are identified from select, clock gate and bus bits 0-3 only.
// - Mode register write/read opcodes, index and payload placement on both edges.
// - Opcodes 0010 and 0011 with clock gate high decode per-bank/all-bank refresh.
// - Activate opcode low,high; row bits spread over rising and falling halves.
// - Rising bits 7-9 carry the bank for activate, read, write, precharge.
// - Read/write opcodes, column bits over both halves, column bit 0 is zero.
// - Falling bit 0 high on read or write requests auto precharge.
// - Precharge opcode 1101; rising bit 4 selects all banks, ignoring bank.
// - Clock gate low on consecutive edges keeps the current low-power state.
// - Clock gate rising with select high exits any low-power state.
// - Select and clock gate sampled on rising edge; bus sampled on both edges.
package lpcd_pkg;

    localparam int CA_WIDTH = 10;
    localparam int CLK_PERIOD_NS = 10;

    // Exit delay in nanoseconds; the clock must toggle at least twice within it
    localparam int PD_EXIT_DELAY_NS = 20;
    localparam int PD_EXIT_CYCLES = (PD_EXIT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CKE_SETTLE_CYCLES = 2;

    // Opcodes, bit 0 of the bus is the lsb
    localparam logic [3:0] OP_MRW   = 4'h0;
    localparam logic [3:0] OP_MRR   = 4'h8;
    localparam logic [3:0] OP_REFPB = 4'h4;
    localparam logic [3:0] OP_REFAB = 4'hc;
    localparam logic [3:0] OP_PRE   = 4'hb;
    localparam logic [1:0] OP_ACT   = 2'h2;
    localparam logic [2:0] OP_RD    = 3'h5;
    localparam logic [2:0] OP_WR    = 3'h1;
    localparam logic [2:0] OP_NOP   = 3'h7;
    localparam logic [2:0] OP_SELF_REFRESH_STATE  = 3'h4;
    localparam logic [2:0] OP_DPD   = 3'h3;

    // Field positions on the rising and falling halves
    localparam int BANK_LSB = 7;
    localparam int MRI_LSB = 4;
    localparam int AUTO_CLOSE_BIT = 0;
    localparam int ALL_BANKS_BIT = 4;

    typedef enum logic [8:0] {
        CMD_NONE  = 9'h001,
        CMD_MRW   = 9'h002,
        CMD_MRR   = 9'h004,
        CMD_REFPB = 9'h008,
        CMD_REFAB = 9'h010,
        CMD_ACT   = 9'h020,
        CMD_RD    = 9'h040,
        CMD_WR    = 9'h080,
        CMD_PRE   = 9'h100
    } lpcd_kind_type;

    typedef enum logic [3:0] {
        PWR_ACTIVE = 4'h1,
        PWR_PD     = 4'h2,
        PWR_SELF_REFRESH_STATE   = 4'h4,
        PWR_DPD    = 4'h8
    } lpcd_pwr_type;

    typedef struct packed {
        lpcd_kind_type kind;
        logic [2:0]    array_group_sel;
        logic [14:0]   row_index_bits;
        logic [11:0]   col_index_bits;
        logic [7:0]    mode_reg_index;
        logic [7:0]    mode_reg_payload;
        logic          auto_close_flag;
        logic          all_banks_flag;
    } lpcd_cmd_type;

    localparam lpcd_cmd_type CMD_RESET = '{kind: CMD_NONE, default: '0};

endpackage : lpcd_pkg

// ==== src/lpcd_ddr_capture.sv ====
// Captures the command/address bus on both clock edges.
// Assumes the bus is stable around each edge of ref_clk.
`timescale 1ns/10ps
module lpcd_ddr_capture #(
    parameter int WIDTH = 10
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] bus_in,
    output logic      [WIDTH-1:0] rise_ff,
    output logic      [WIDTH-1:0] fall_ff
);

    generate
        if (WIDTH < 1)
        begin : g_chk
            $error("lpcd_ddr_capture: WIDTH must be positive");
        end
    endgenerate

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            rise_ff <= '0;
        else
            rise_ff <= bus_in;
    end

    // Second half of the command; only read one half cycle later
    always_ff @(negedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            fall_ff <= '0;
        else
            fall_ff <= bus_in;
    end

endmodule : lpcd_ddr_capture

// ==== src/lpcd_gap_timer.sv ====
// Counts down a fixed number of cycles after a start pulse.
// Assumes start is a one-cycle pulse in the ref_clk domain.
`timescale 1ns/10ps
module lpcd_gap_timer #(
    parameter int CYCLES = 2
) (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic start,
    output logic      busy_ff
);

    localparam int CW = $clog2(CYCLES + 1);

    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;

    generate
        if (CYCLES < 1)
        begin : g_chk
            $error("lpcd_gap_timer: CYCLES must be at least one");
        end
    endgenerate

    assign nxt_cnt = start ? CW'(CYCLES) : (cnt_ff != '0) ? cnt_ff - CW'(1) : cnt_ff;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_ff  <= '0;
            busy_ff <= 1'b0;
        end
        else
        begin
            cnt_ff  <= nxt_cnt;
            busy_ff <= (nxt_cnt != '0);
        end
    end

endmodule : lpcd_gap_timer

// ==== test/lpcd_decoder_assertions.sv ====
// Assertions on the command decoder's ports, bound to its top module.
// Assumes pins reach the outputs two rising edges after they are sampled.
`timescale 1ns/10ps
module lpcd_decoder_chk #(
    parameter int CA_W        = 10,
    parameter int EXIT_CYCLES = 2
) (
    input wire logic                   ref_clk,
    input wire logic                   rst_n,
    input wire logic                   select_low,
    input wire logic                   clock_gate_in,
    input wire logic [CA_W-1:0]        cmd_addr_bus,
    input wire logic                   cmd_valid_ff,
    input wire lpcd_pkg::lpcd_cmd_type cmd_ff,
    input wire lpcd_pkg::lpcd_pwr_type pwr_state_ff,
    input wire logic                   illegal_seen_ff
);
    logic       cke_q_ff;
    logic       cmd;
    logic [3:0] op;
    // Set in reset like the decoder's copy, so no false exit is seen
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            cke_q_ff <= 1'b1;
        else
            cke_q_ff <= clock_gate_in;
    end
    assign cmd = !select_low && clock_gate_in && cke_q_ff;
    assign op  = cmd_addr_bus[3:0];
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    property p_nop;
        select_low || op[2:0] == 3'h7 |-> ##2 !cmd_valid_ff;
    endproperty
    a_nop: assert property (p_nop) else $error("idle cycle decoded");
    property p_mrw;
        cmd && op == 4'h0 |-> ##2 cmd_valid_ff && cmd_ff.kind == lpcd_pkg::CMD_MRW
            && cmd_ff.mode_reg_index[5:0] == $past(cmd_addr_bus[9:4], 2);
    endproperty
    a_mrw: assert property (p_mrw) else $error("bad mode write");
    property p_act;
        cmd && op[1:0] == 2'h2 |-> ##2 cmd_ff.kind == lpcd_pkg::CMD_ACT
            && {cmd_ff.array_group_sel, cmd_ff.row_index_bits[12:8]} == $past(cmd_addr_bus[9:2], 2);
    endproperty
    a_act: assert property (p_act) else $error("bad activate");
    property p_rw;
        cmd && op[1:0] == 2'h1 |-> ##2 cmd_ff.col_index_bits[2:0] == {$past(cmd_addr_bus[6:5], 2), 1'b0}
            && cmd_ff.kind == ($past(op[2], 2) ? lpcd_pkg::CMD_RD : lpcd_pkg::CMD_WR);
    endproperty
    a_rw: assert property (p_rw) else $error("bad column access");
    property p_pd;
        cke_q_ff && !clock_gate_in && select_low |-> ##2 pwr_state_ff == lpcd_pkg::PWR_PD;
    endproperty
    a_pd: assert property (p_pd) else $error("no power-down entry");
    property p_keep;
        !clock_gate_in ##1 !clock_gate_in |-> ##2 $stable(pwr_state_ff);
    endproperty
    a_keep: assert property (p_keep) else $error("low-power state left");
    property p_exit;
        !cke_q_ff && clock_gate_in && select_low |-> ##2 pwr_state_ff == lpcd_pkg::PWR_ACTIVE;
    endproperty
    a_exit: assert property (p_exit) else $error("no exit");
    property p_bad;
        cmd && op == 4'h3 |-> ##2 !cmd_valid_ff && illegal_seen_ff;
    endproperty
    a_bad: assert property (p_bad) else $error("unknown opcode taken");
endmodule : lpcd_decoder_chk

bind lpcd_decoder lpcd_decoder_chk #(.CA_W(CA_W), .EXIT_CYCLES(EXIT_CYCLES)) u_chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .select_low(select_low),
    .clock_gate_in(clock_gate_in), .cmd_addr_bus(cmd_addr_bus), .cmd_valid_ff(cmd_valid_ff),
    .cmd_ff(cmd_ff), .pwr_state_ff(pwr_state_ff), .illegal_seen_ff(illegal_seen_ff)
);

// ==== test/lpcd_ctrl_model.sv ====
// Memory controller model driving select, clock gate and the DDR command bus.
// Assumes each cycle is started just after a falling clock edge.
`timescale 1ns/10ps
module lpcd_ctrl_model #(
    parameter int EXIT_WAIT = 2
) (
    input  wire logic  ref_clk,
    output logic       select_low,
    output logic       clock_gate_in,
    output logic [9:0] cmd_addr_bus
);
    logic [9:0] hold;
    initial
    begin
        select_low    = 1'b1;
        clock_gate_in = 1'b1;
        hold          = 10'h155;
        cmd_addr_bus  = hold;
    end
    // Deselected bus is not driven; a toggling value stands in for a floating line
    task automatic cyc(input logic s, input logic c, input logic [9:0] r, input logic [9:0] f);
        select_low    = s;
        clock_gate_in = c;
        hold          = s ? ~hold : r;
        cmd_addr_bus  = hold;
        @(posedge ref_clk);
        #1;
        hold          = s ? ~hold : f;
        cmd_addr_bus  = hold;
        @(negedge ref_clk);
        #1;
    endtask : cyc
    task automatic idle_cycle_cmd(input int n, input logic c);
        repeat (n) cyc(1'b1, c, 10'h000, 10'h000);
    endtask : idle_cycle_cmd
    task automatic enter_lp(input logic s, input logic [9:0] code);
        cyc(s, 1'b0, code, 10'h000);
        idle_cycle_cmd(2, 1'b0);
    endtask : enter_lp
    // Only idle cycles until the exit delay is over
    task automatic exit_lp();
        cyc(1'b1, 1'b1, 10'h000, 10'h000);
        idle_cycle_cmd(EXIT_WAIT + 1, 1'b1);
    endtask : exit_lp
endmodule : lpcd_ctrl_model

// ==== test/tb_lpddr_ca_command_decoder.sv ====
// Self-checking bench of the command decoder with a controller model on its pins.
// Assumes the checker is bound to the decoder; clock is 100 MHz.
`timescale 1ns/10ps
`define CHK(a, b) \
    samples_checked++; \
    if ((a) !== (b)) \
    begin \
        num_errors++; \
        $display("ERROR %0t: got %h, expected %h", $time, (a), (b)); \
    end
module tb_lpddr_ca_command_decoder;
    localparam int EXIT = 3;
    logic                   ref_clk = 1'b0;
    logic                   rst_n   = 1'b0;
    logic                   select_low;
    logic                   clock_gate_in;
    logic [9:0]             cmd_addr_bus;
    logic                   cmd_valid_ff;
    lpcd_pkg::lpcd_cmd_type cmd_ff;
    lpcd_pkg::lpcd_pwr_type pwr_state_ff;
    logic                   exit_window_ff;
    logic                   illegal_seen_ff;
    logic                   reinit_needed_ff;
    int                     num_errors      = 0;
    int                     samples_checked = 0;
    int                     n_valid         = 0;
    int                     n_win           = 0;
    logic [9:0]             q_r[$];
    logic [9:0]             q_f[$];
    lpcd_pkg::lpcd_cmd_type q_e[$];
    lpcd_ctrl_model #(.EXIT_WAIT(EXIT)) ctl (
        .ref_clk(ref_clk), .select_low(select_low), .clock_gate_in(clock_gate_in),
        .cmd_addr_bus(cmd_addr_bus)
    );
    lpcd_decoder #(.CA_W(10), .EXIT_CYCLES(EXIT)) dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .select_low(select_low),
        .clock_gate_in(clock_gate_in), .cmd_addr_bus(cmd_addr_bus), .cmd_valid_ff(cmd_valid_ff),
        .cmd_ff(cmd_ff), .pwr_state_ff(pwr_state_ff), .exit_window_ff(exit_window_ff),
        .illegal_seen_ff(illegal_seen_ff), .reinit_needed_ff(reinit_needed_ff)
    );
    always #5 ref_clk = ~ref_clk;
    // Pulses and window cycles are counted, since they stand for one cycle only
    always @(posedge ref_clk)
    begin
        n_valid += (cmd_valid_ff === 1'b1);
        n_win   += (exit_window_ff === 1'b1);
    end
    task automatic results();
        if (num_errors == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results
    task automatic do_reset();
        @(posedge ref_clk);
        #1;
        rst_n = 1'b0;
        repeat (10) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        @(negedge ref_clk);
        #1;
        ctl.idle_cycle_cmd(3, 1'b1);
    endtask : do_reset
    task automatic add(input logic [9:0] r, input logic [9:0] f, input lpcd_pkg::lpcd_cmd_type e);
        q_r.push_back(r);
        q_f.push_back(f);
        q_e.push_back(e);
    endtask : add
    // Back to back; each result shows in the next command's cycle and is checked at its end
    task automatic t_stream();
        for (int i = 0; i <= q_r.size(); i++)
        begin
            if (i < q_r.size())
                ctl.cyc(1'b0, 1'b1, q_r[i], q_f[i]);
            else
                ctl.idle_cycle_cmd(1, 1'b1);
            if (i > 0)
            begin
                `CHK(cmd_valid_ff, 1'b1)
                `CHK(cmd_ff, q_e[i-1])
            end
        end
    endtask : t_stream
    task automatic t_nop();
        int n0;
        ctl.idle_cycle_cmd(1, 1'b1);
        n0 = n_valid;
        ctl.idle_cycle_cmd(2, 1'b1);
        ctl.cyc(1'b0, 1'b1, 10'h3ff, 10'h000);
        ctl.cyc(1'b0, 1'b1, 10'h2c7, 10'h155);
        ctl.idle_cycle_cmd(2, 1'b1);
        `CHK(n_valid, n0)
        `CHK(cmd_ff.kind, lpcd_pkg::CMD_REFAB)
        `CHK(illegal_seen_ff, 1'b0)
    endtask : t_nop
    task automatic t_lp(input logic s, input logic [9:0] code, input lpcd_pkg::lpcd_pwr_type st,
        input logic rein);
        ctl.enter_lp(s, code);
        ctl.cyc(1'b0, 1'b0, 10'h3c7, 10'h0aa);
        ctl.idle_cycle_cmd(1, 1'b0);
        `CHK(pwr_state_ff, st)
        n_win = 0;
        ctl.exit_lp();
        ctl.idle_cycle_cmd(4, 1'b1);
        `CHK(pwr_state_ff, lpcd_pkg::PWR_ACTIVE)
        `CHK(n_win, EXIT)
        `CHK({reinit_needed_ff, illegal_seen_ff}, {rein, 1'b0})
    endtask : t_lp
    task automatic t_bad();
        int n0;
        n0 = n_valid;
        ctl.cyc(1'b0, 1'b1, 10'h3f3, 10'h000);
        ctl.idle_cycle_cmd(2, 1'b1);
        `CHK(n_valid, n0)
        `CHK({illegal_seen_ff, reinit_needed_ff}, 2'h3)
        do_reset();
        `CHK({illegal_seen_ff, reinit_needed_ff}, 2'h0)
    endtask : t_bad
    initial
    begin
        do_reset();
        `CHK(cmd_valid_ff, 1'b0)
        `CHK(cmd_ff, lpcd_pkg::CMD_RESET)
        `CHK(pwr_state_ff, lpcd_pkg::PWR_ACTIVE)
        `CHK({illegal_seen_ff, reinit_needed_ff}, 2'h0)
        add({6'h25, 4'h0}, {8'h3c, 2'h2}, {lpcd_pkg::CMD_MRW, 30'h0, 16'ha53c, 2'h0});
        add({6'h3f, 4'h8}, {8'h5a, 2'h3}, {lpcd_pkg::CMD_MRR, 30'h0, 16'hff00, 2'h0});
        add({3'h5, 5'h1a, 2'h2}, {2'h3, 8'hbc}, {lpcd_pkg::CMD_ACT, 3'h5, 15'h7abc, 30'h0});
        add({3'h7, 4'hc, 3'h5}, {9'h1ff, 1'b1}, {lpcd_pkg::CMD_RD, 3'h7, 15'h0, 12'hffe, 18'h2});
        add({3'h0, 4'h0, 3'h1}, {9'h001, 1'b0}, {lpcd_pkg::CMD_WR, 3'h0, 15'h0, 12'h008, 18'h0});
        add({3'h3, 3'h0, 4'hb}, 10'h3ff, {lpcd_pkg::CMD_PRE, 3'h3, 45'h0});
        add({3'h6, 3'h1, 4'hb}, 10'h2aa, {lpcd_pkg::CMD_PRE, 3'h0, 45'h1});
        add({6'h2a, 4'h4}, 10'h2aa, {lpcd_pkg::CMD_REFPB, 48'h0});
        add({6'h15, 4'hc}, 10'h155, {lpcd_pkg::CMD_REFAB, 48'h0});
        t_stream();
        t_nop();
        t_lp(1'b1, 10'h000, lpcd_pkg::PWR_PD, 1'b0);
        t_lp(1'b0, 10'h004, lpcd_pkg::PWR_SELF_REFRESH_STATE, 1'b0);
        ctl.cyc(1'b0, 1'b1, 10'h01b, 10'h000);
        ctl.idle_cycle_cmd(1, 1'b1);
        t_lp(1'b0, 10'h003, lpcd_pkg::PWR_DPD, 1'b1);
        do_reset();
        t_bad();
        results();
    end
    // Hang guard
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        num_errors++;
        results();
    end
endmodule : tb_lpddr_ca_command_decoder
